// ==== osc_clk_pkg.sv ====
// constants, register layouts and types for the oscillator control block
`default_nettype none
package osc_clk_pkg;
    // register byte addresses
    localparam logic [7:0] A_OSC = 8'h00;
    localparam logic [7:0] A_DIV = 8'h04;
    localparam logic [7:0] A_MAPI = 8'h08;
    localparam logic [7:0] A_MAPO = 8'h0c;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;
    // unlock keys for the low byte of oscillator_control
    localparam logic [7:0] KEY1 = 8'h46;
    localparam logic [7:0] KEY2 = 8'h57;
    // oscillator_control layout
    typedef struct packed {
        logic [4:0] rsv_hi;
        logic [2:0] new_osc_select;
        logic rsv7;
        logic pin_map_lock;
        logic [1:0] rsv54;
        logic clock_fail_flag;
        logic rsv2;
        logic secondary_osc_enable;
        logic osc_switch_request;
    } osc_ctrl_t;
    // clock_divider_control layout
    typedef struct packed {
        logic recover_on_interrupt;
        logic [2:0] cpu_clock_reduction;
        logic reduction_enable;
        logic [2:0] rc_postscaler;
        logic [1:0] pll_output_divider;
        logic rsv5;
        logic [4:0] pll_input_prescaler;
    } clk_div_t;
    localparam logic [15:0] OSC_RST = 16'h0000;
    localparam logic [15:0] DIV_RST = 16'h3040;
    localparam logic [15:0] OSC_WMASK = 16'h074b;
    localparam logic [15:0] DIV_WMASK = 16'hffdf;
    localparam logic [1:0] POST_RSVD = 2'h2;
    localparam logic [5:0] PRE_OFS = 6'h02;
    // interrupt status bit positions
    localparam int IRQ_CF = 0;
    localparam int IRQ_SW = 1;
    localparam int IRQ_MM = 2;
    localparam int NIRQ = 3;
    // unlock sequence states
    typedef enum logic [1:0] {
        K_IDLE = 2'b00,
        K_ONE = 2'b01,
        K_ARMED = 2'b10
    } key_st_t;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ==== osc_clock_divider_pin_lock.sv ====
// oscillator control, clock dividers and keyed pin map lock with AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
module osc_clock_divider_pin_lock
    import osc_clk_pkg::*;
#(
    parameter int MAP_W = 16
) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic FAIL_SAFE_CLOCK_MONITOR_FAIL_I,
    input wire logic SWITCH_DONE_I,
    input wire logic INTR_I,
    input wire logic ONE_SESSION_FUSE_I,
    output logic SEC_OSC_EN_O,
    output logic SWITCH_REQ_O,
    output logic [2:0] NEW_OSC_O,
    output logic [MAP_W-1:0] MAP_IN_O,
    output logic [MAP_W-1:0] MAP_OUT_O,
    output logic MISMATCH_RST_O,
    output logic CPU_CLK_EN_O,
    output logic FRC_CLK_EN_O,
    output logic [5:0] PLL_PRE_DIV_O,
    output logic [3:0] PLL_POST_DIV_O,
    output logic IRQ_O
);
    // merge written byte lanes into a 16-bit register
    function automatic logic [15:0] mrg(input logic [15:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
        mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction
    function automatic logic known(input logic [7:0] a);
        known = (a == A_OSC) || (a == A_DIV) || (a == A_MAPI) || (a == A_MAPO) ||
                (a == A_ISTAT) || (a == A_IMASK);
    endfunction
    function automatic logic [8:0] frc_div(input logic [2:0] c);
        case (c)
            3'h0: frc_div = 9'h001;
            3'h1: frc_div = 9'h002;
            3'h2: frc_div = 9'h004;
            3'h3: frc_div = 9'h008;
            3'h4: frc_div = 9'h010;
            3'h5: frc_div = 9'h020;
            3'h6: frc_div = 9'h040;
            default: frc_div = 9'h100;
        endcase
    endfunction

    logic rst_s1_q, rst_n;
    logic [3:0] in_s1_q, in_s2_q;
    logic fail_d_q;
    logic fail_s, done_s, intr_s, fuse_s;
    logic aw_ok_q, w_ok_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic do_wr;
    key_st_t key_q;
    osc_ctrl_t osc_q, osc_w;
    clk_div_t div_q, div_w;
    logic [MAP_W-1:0] mapi_q, mapo_q, shi_q, sho_q;
    logic [NIRQ-1:0] ist_q, imask_q, ev;
    logic irq_q, mm_q;
    logic [6:0] cpu_cnt_q;
    logic cpu_en_q;
    logic [8:0] frc_cnt_q;
    logic frc_en_q;
    logic [5:0] pre_q;
    logic [3:0] post_q;
    logic [31:0] rd_mux;

    // reset release through two flops
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // pin inputs pass two flops; edge detect reads only the second
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            in_s1_q <= 4'h0;
            in_s2_q <= 4'h0;
            fail_d_q <= 1'b0;
        end else begin
            in_s1_q <= {ONE_SESSION_FUSE_I, INTR_I, SWITCH_DONE_I, FAIL_SAFE_CLOCK_MONITOR_FAIL_I};
            in_s2_q <= in_s1_q;
            fail_d_q <= in_s2_q[0];
        end
    end
    assign fail_s = in_s2_q[0] & ~fail_d_q;
    assign done_s = in_s2_q[1];
    assign intr_s = in_s2_q[2];
    assign fuse_s = in_s2_q[3];

    // AXI4-Lite write channels, taken in either order
    assign do_wr = aw_ok_q & w_ok_q & ~bvalid_q;
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (!aw_ok_q && !bvalid_q && !do_wr)
                awready_q <= ~(AWVALID_I & awready_q);
            if (!w_ok_q && !bvalid_q && !do_wr)
                wready_q <= ~(WVALID_I & wready_q);
            if (AWVALID_I && awready_q) begin
                aw_ok_q <= 1'b1;
                awaddr_q <= AWADDR_I;
            end
            if (WVALID_I && wready_q) begin
                w_ok_q <= 1'b1;
                wdata_q <= WDATA_I;
                wstrb_q <= WSTRB_I;
            end
            if (do_wr) begin
                // locked map writes still answer OKAY
                bvalid_q <= 1'b1;
                bresp_q <= known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
            end else if (bvalid_q && BREADY_I) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // read channel, data one cycle after the address is taken
    always_comb begin
        case (ARADDR_I)
            A_OSC: rd_mux = {16'h0, osc_q};
            A_DIV: rd_mux = {16'h0, div_q};
            A_MAPI: rd_mux = 32'(mapi_q);
            A_MAPO: rd_mux = 32'(mapo_q);
            A_ISTAT: rd_mux = 32'(ist_q);
            A_IMASK: rd_mux = 32'(imask_q);
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ARVALID_I && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= known(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && RREADY_I) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // unlock key sequence: two keys, then one armed write
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            key_q <= K_IDLE;
        end else if (do_wr && awaddr_q == A_OSC) begin
            case (key_q)
                K_IDLE: key_q <= (wstrb_q[0] && wdata_q[7:0] == KEY1) ? K_ONE : K_IDLE;
                K_ONE: key_q <= (wstrb_q[0] && wdata_q[7:0] == KEY2) ? K_ARMED : K_IDLE;
                K_ARMED: key_q <= K_IDLE;
                default: key_q <= K_IDLE;
            endcase
        end
    end

    // oscillator control, kept until power-on reset
    assign osc_w = mrg(osc_q, wdata_q, wstrb_q) & OSC_WMASK;
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= OSC_RST;
        end else begin
            if (do_wr && awaddr_q == A_OSC && key_q == K_ARMED) begin
                osc_q.new_osc_select <= osc_w.new_osc_select;
                osc_q.secondary_osc_enable <= osc_w.secondary_osc_enable;
                if (osc_w.osc_switch_request)
                    osc_q.osc_switch_request <= 1'b1;
                if (!osc_w.clock_fail_flag)
                    osc_q.clock_fail_flag <= 1'b0;
                // one-way fuse keeps a set lock set
                if (!(fuse_s && osc_q.pin_map_lock))
                    osc_q.pin_map_lock <= osc_w.pin_map_lock;
            end
            if (osc_q.osc_switch_request && done_s)
                osc_q.osc_switch_request <= 1'b0;
            if (fail_s)
                osc_q.clock_fail_flag <= 1'b1;
        end
    end

    // clock divider control; interrupt recovery overrides software
    assign div_w = mrg(div_q, wdata_q, wstrb_q) & DIV_WMASK;
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= DIV_RST;
        end else begin
            if (do_wr && awaddr_q == A_DIV) begin
                div_q.recover_on_interrupt <= div_w.recover_on_interrupt;
                div_q.cpu_clock_reduction <= div_w.cpu_clock_reduction;
                div_q.reduction_enable <= div_w.reduction_enable;
                div_q.rc_postscaler <= div_w.rc_postscaler;
                div_q.pll_input_prescaler <= div_w.pll_input_prescaler;
                // the reserved output divider code is never stored
                if (div_w.pll_output_divider != POST_RSVD)
                    div_q.pll_output_divider <= div_w.pll_output_divider;
            end
            if (div_q.recover_on_interrupt && intr_s)
                div_q.reduction_enable <= 1'b0;
        end
    end

    // pin mapping registers with shadow copies, writable only when unlocked
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            mapi_q <= '0;
            mapo_q <= '0;
            shi_q <= '0;
            sho_q <= '0;
        end else if (do_wr && !osc_q.pin_map_lock) begin
            if (awaddr_q == A_MAPI) begin
                mapi_q <= wdata_q[MAP_W-1:0];
                shi_q <= wdata_q[MAP_W-1:0];
            end
            if (awaddr_q == A_MAPO) begin
                mapo_q <= wdata_q[MAP_W-1:0];
                sho_q <= wdata_q[MAP_W-1:0];
            end
        end
    end
    // any disagreement with the shadows requests a mismatch reset
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n)
            mm_q <= 1'b0;
        else
            mm_q <= (mapi_q != shi_q) || (mapo_q != sho_q);
    end

    // sticky interrupt status, write one to clear, set wins
    assign ev = {mm_q, osc_q.osc_switch_request & done_s, fail_s};
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= '0;
            imask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (do_wr && awaddr_q == A_ISTAT && wstrb_q[0])
                ist_q <= (ist_q & ~wdata_q[NIRQ-1:0]) | ev;
            else
                ist_q <= ist_q | ev;
            if (do_wr && awaddr_q == A_IMASK && wstrb_q[0])
                imask_q <= wdata_q[NIRQ-1:0];
            irq_q <= |(ist_q & imask_q);
        end
    end

    // processor clock enable: 1:1 unless reduction is enabled
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            cpu_cnt_q <= 7'h0;
            cpu_en_q <= 1'b0;
        end else begin
            cpu_cnt_q <= cpu_cnt_q + 7'h1;
            if (div_q.reduction_enable)
                cpu_en_q <= (cpu_cnt_q & 7'((7'h1 << div_q.cpu_clock_reduction) - 7'h1))
                            == 7'h0;
            else
                cpu_en_q <= 1'b1;
        end
    end

    // RC postscaler enable pulse and PLL divider values
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            frc_cnt_q <= 9'h0;
            frc_en_q <= 1'b0;
            pre_q <= 6'h0;
            post_q <= 4'h0;
        end else begin
            if (frc_cnt_q >= frc_div(div_q.rc_postscaler) - 9'h1) begin
                frc_cnt_q <= 9'h0;
                frc_en_q <= 1'b1;
            end else begin
                frc_cnt_q <= frc_cnt_q + 9'h1;
                frc_en_q <= 1'b0;
            end
            pre_q <= {1'b0, div_q.pll_input_prescaler} + PRE_OFS;
            // code 11 shifts by two so the divide-by-8 result stays inside four bits
            post_q <= 4'(4'h2 << (div_q.pll_output_divider
                      - 2'(div_q.pll_output_divider[1])));
        end
    end

    assign AWREADY_O = awready_q;
    assign WREADY_O = wready_q;
    assign BVALID_O = bvalid_q;
    assign BRESP_O = bresp_q;
    assign ARREADY_O = arready_q;
    assign RVALID_O = rvalid_q;
    assign RDATA_O = rdata_q;
    assign RRESP_O = rresp_q;
    assign SEC_OSC_EN_O = osc_q.secondary_osc_enable;
    assign SWITCH_REQ_O = osc_q.osc_switch_request;
    assign NEW_OSC_O = osc_q.new_osc_select;
    assign MAP_IN_O = mapi_q;
    assign MAP_OUT_O = mapo_q;
    assign MISMATCH_RST_O = mm_q;
    assign CPU_CLK_EN_O = cpu_en_q;
    assign FRC_CLK_EN_O = frc_en_q;
    assign PLL_PRE_DIV_O = pre_q;
    assign PLL_POST_DIV_O = post_q;
    assign IRQ_O = irq_q;

    // checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_n);
    property p_cf_set;
        fail_s |=> osc_q.clock_fail_flag;
    endproperty
    a_cf_set: assert property (p_cf_set) else $error("fail flag not set");
    property p_cf_hold;
        osc_q.clock_fail_flag && !(do_wr && key_q == K_ARMED) |=> osc_q.clock_fail_flag;
    endproperty
    a_cf_hold: assert property (p_cf_hold) else $error("fail flag lost");
    property p_sw_done;
        osc_q.osc_switch_request && done_s |=> !SWITCH_REQ_O ##1 !SWITCH_REQ_O;
    endproperty
    a_sw_done: assert property (p_sw_done) else $error("switch request stuck");
    property p_nokey;
        do_wr && awaddr_q == A_OSC && key_q != K_ARMED |=> $stable(osc_q.secondary_osc_enable);
    endproperty
    a_nokey: assert property (p_nokey) else $error("write without unlock");
    property p_roi;
        div_q.recover_on_interrupt && intr_s |=> !div_q.reduction_enable ##1 CPU_CLK_EN_O;
    endproperty
    a_roi: assert property (p_roi) else $error("interrupt did not recover");
    property p_lock;
        do_wr && osc_q.pin_map_lock |=> $stable(mapi_q) && $stable(mapo_q);
    endproperty
    a_lock: assert property (p_lock) else $error("locked map changed");
    property p_fuse;
        fuse_s && osc_q.pin_map_lock |=> osc_q.pin_map_lock;
    endproperty
    a_fuse: assert property (p_fuse) else $error("one-way lock cleared");
    property p_post;
        div_q.pll_output_divider != POST_RSVD;
    endproperty
    a_post: assert property (p_post) else $error("reserved divider stored");
    property p_pre;
        $stable(div_q.pll_input_prescaler) |=>
            pre_q == {1'b0, $past(div_q.pll_input_prescaler)} + PRE_OFS;
    endproperty
    a_pre: assert property (p_pre) else $error("prescaler value moved");
    c_armed: cover property (key_q == K_ARMED ##1 key_q == K_IDLE);
    c_switch: cover property (osc_q.osc_switch_request ##1 !osc_q.osc_switch_request);
    c_doze: cover property (div_q.reduction_enable && div_q.cpu_clock_reduction == 3'h7);
endmodule // osc_clock_divider_pin_lock
`default_nettype wire

// ==== tb.sv ====
// self-checking testbench for the oscillator control and pin map lock block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import osc_clk_pkg::*;
    localparam logic [1:0] OK = RESP_OKAY;
    logic clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fail, done, intr, fuse;
    logic sec_en, sw_req, mm_rst, cpu_en, frc_en, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, post_div;
    logic [1:0] bresp, rresp;
    logic [2:0] new_osc;
    logic [15:0] map_in, map_out, r1, r2;
    logic [5:0] pre_div;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    clk_div_t dv;
    int n_fail, tests_run, seed, p;
    int frc_tab[8] = '{1, 2, 4, 8, 16, 32, 64, 256};

    osc_clock_divider_pin_lock #(.MAP_W(16)) i_osc_clock_divider_pin_lock (
        .CLK_SYS_I(clk), .RSTN_I(rstn), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .FAIL_SAFE_CLOCK_MONITOR_FAIL_I(fail),
        .SWITCH_DONE_I(done), .INTR_I(intr), .ONE_SESSION_FUSE_I(fuse),
        .SEC_OSC_EN_O(sec_en), .SWITCH_REQ_O(sw_req), .NEW_OSC_O(new_osc),
        .MAP_IN_O(map_in), .MAP_OUT_O(map_out), .MISMATCH_RST_O(mm_rst),
        .CPU_CLK_EN_O(cpu_en), .FRC_CLK_EN_O(frc_en), .PLL_PRE_DIV_O(pre_div),
        .PLL_POST_DIV_O(post_div), .IRQ_O(irq)
    );

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic give_verdict;
        $display("checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // pin level compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bus result compare, response code above data
    task automatic cmp_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // take the oldest note whenever a bus answer is handed over
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (rq.size() != 0) cmp_bus("read", rq.pop_front(), {rresp, rdata});
            else cmp_bus("read", '1, {rresp, rdata});
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (bq.size() != 0) cmp_bus("bresp", {bq.pop_front(), 32'h0}, {bresp, 32'h0});
            else cmp_bus("bresp", '1, {bresp, 32'h0});
        end
    end

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bq.push_back(OK);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    // one read, expected data and response noted first
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        rq.push_back({er, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic unlock(input logic [15:0] d);
        wr(A_OSC, {8'h00, KEY1});
        wr(A_OSC, {8'h00, KEY2});
        wr(A_OSC, d);
    endtask

    // spacing of enable pulses; earlier intervals may still follow the old divisor
    task automatic per(input logic cpu, output int n);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while ((cpu ? cpu_en : frc_en) !== 1'b1 && n < 600);
        end
    endtask

    // hang guard
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end

    // main sequence
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        {fail, done, intr, fuse} = '0;
        wstrb = 4'hf;
        rstn = 1'b0;
        n_fail = 0;
        tests_run = 0;
        seed = 57;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(A_OSC, {16'h0, OSC_RST}, OK);
        rd(A_DIV, {16'h0, DIV_RST}, OK);
        chk("post_div", 32'(post_div), 4);
        rd(8'h20, 32'h0, RESP_SLVERR);
        // keyless and aborted sequences leave the register alone
        wr(A_OSC, 16'h0002);
        wr(A_OSC, {8'h00, KEY1});
        wr(A_OSC, 16'h00ff);
        wr(A_OSC, {8'h00, KEY2});
        wr(A_OSC, 16'h0002);
        rd(A_OSC, 32'h0, OK);
        unlock(16'h0002);
        settle(3);
        chk("sec_en", 32'(sec_en), 1);
        // several map updates in one unlocked session
        r1 = 16'($random(seed));
        r2 = 16'($random(seed));
        wr(A_MAPI, r1);
        wr(A_MAPO, r2);
        wr(A_MAPI, r2);
        settle(3);
        chk("map_in", 32'(map_in), 32'(r2));
        chk("map_out", 32'(map_out), 32'(r2));
        unlock(16'h0042);
        wr(A_MAPI, r1);
        rd(A_MAPI, {16'h0, r2}, OK);
        chk("map_in", 32'(map_in), 32'(r2));
        // unprogrammed fuse: a second session is allowed
        unlock(16'h0002);
        wr(A_MAPI, r1);
        rd(A_MAPI, {16'h0, r1}, OK);
        // one-session fuse: once locked, no unlock
        fuse <= 1'b1;
        settle(4);
        unlock(16'h0042);
        unlock(16'h0000);
        rd(A_OSC, 32'h0040, OK);
        wr(A_MAPO, r1);
        rd(A_MAPO, {16'h0, r2}, OK);
        // reset clears registers and reopens remapping
        rstn <= 1'b0;
        settle(2);
        rstn <= 1'b1;
        settle(4);
        rd(A_OSC, 32'h0, OK);
        rd(A_DIV, {16'h0, DIV_RST}, OK);
        wr(A_MAPI, r2);
        rd(A_MAPI, {16'h0, r2}, OK);
        // postscaler and processor clock reduction for every code
        for (int c = 0; c < 8; c++) begin
            dv = '0;
            dv.rc_postscaler = 3'(c);
            dv.cpu_clock_reduction = 3'(c);
            dv.reduction_enable = 1'b1;
            dv.pll_output_divider = 2'b01;
            wr(A_DIV, dv);
            per(1'b0, p);
            chk("frc_period", p, frc_tab[c]);
            per(1'b1, p);
            chk("cpu_period", p, 1 << c);
        end
        dv.reduction_enable = 1'b0;
        wr(A_DIV, dv);
        per(1'b1, p);
        chk("cpu_period", p, 1);
        // pll dividers, reserved output code ignored
        dv.pll_output_divider = 2'b00;
        dv.pll_input_prescaler = 5'h01;
        wr(A_DIV, dv);
        settle(3);
        chk("post_div", 32'(post_div), 2);
        chk("pre_div", 32'(pre_div), 3);
        dv.pll_output_divider = 2'b11;
        dv.pll_input_prescaler = 5'h1f;
        wr(A_DIV, dv);
        settle(3);
        chk("post_div", 32'(post_div), 8);
        chk("pre_div", 32'(pre_div), 33);
        dv.pll_output_divider = POST_RSVD;
        dv.pll_input_prescaler = 5'($random(seed));
        wr(A_DIV, dv);
        settle(3);
        chk("pre_div", 32'(pre_div), 32'(dv.pll_input_prescaler) + 2);
        dv.pll_output_divider = 2'b11;
        rd(A_DIV, {16'h0, dv}, OK);
        // interrupt recovery off, then on
        dv.reduction_enable = 1'b1;
        intr <= 1'b1;
        wr(A_DIV, dv);
        settle(4);
        rd(A_DIV, {16'h0, dv}, OK);
        dv.recover_on_interrupt = 1'b1;
        wr(A_DIV, dv);
        settle(4);
        dv.reduction_enable = 1'b0;
        rd(A_DIV, {16'h0, dv}, OK);
        per(1'b1, p);
        chk("cpu_period", p, 1);
        intr <= 1'b0;
        // clock failure: sticky flag, masked then unmasked interrupt
        fail <= 1'b1;
        settle(6);
        chk("irq", 32'(irq), 0);
        rd(A_ISTAT, 32'h1, OK);
        wr(A_IMASK, 16'h0001);
        settle(3);
        chk("irq", 32'(irq), 1);
        wr(A_ISTAT, 16'h0001);
        settle(3);
        chk("irq", 32'(irq), 0);
        rd(A_OSC, 32'h0008, OK);
        unlock(16'h0000);
        rd(A_OSC, 32'h0, OK);
        fail <= 1'b0;
        // switch to a plain source, never PLL to PLL directly
        unlock(16'h0701);
        settle(3);
        chk("sw_req", 32'(sw_req), 1);
        chk("new_osc", 32'(new_osc), 7);
        done <= 1'b1;
        settle(6);
        chk("sw_req", 32'(sw_req), 0);
        rd(A_OSC, 32'h0700, OK);
        done <= 1'b0;
        chk("mismatch", 32'(mm_rst), 0);
        settle(4);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
